// file: inc/timer_trig_pkg.sv
package timer_trig_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] OFF_START = 8'h04;
   localparam logic [7:0] OFF_STOP = 8'h08;
   localparam logic [7:0] OFF_RUN = 8'h0C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFF_KEY = 8'h14;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CHAN0_IRQ_BIT = 7;
   localparam int CHAN1_STOP_POS = 1;
   localparam int KEY_DOWN_POS = 0;
   localparam int KEY_DONE_POS = 1;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [1:0] RUN_RESET = 2'h0;
   localparam logic [7:0] START_VALID = 8'h03;
   localparam logic [7:0] STOP_VALID = 8'h02;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } apb_req_t;
endpackage

// file: src/key_once.sv
`timescale 1ns/1ps
module key_once (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic key_down,
   output logic key_event,
   output logic key_done
);
   logic done_r, done_nxt, ev_r, ev_nxt;

   always_comb begin
      done_nxt = done_r;
      ev_nxt = 1'b0;
      if (!key_down) begin
         done_nxt = 1'b0;
      end else if (!done_r) begin
         ev_nxt = 1'b1;
         done_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r <= 1'b0;
         ev_r <= 1'b0;
      end else begin
         done_r <= done_nxt;
         ev_r <= ev_nxt;
      end
   end

   assign key_event = ev_r;
   assign key_done = done_r;
endmodule // key_once

// file: src/timer_start_stop_triggers.sv
`timescale 1ns/1ps
module timer_start_stop_triggers (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chan0_event,
   input wire logic key_down,
   output logic [1:0] chan_run_enable,
   output logic start_pulse_0,
   output logic start_pulse_1,
   output logic irq
);
   import timer_trig_pkg::*;

   // ----------------------------------------
   // Local types and helpers
   // ----------------------------------------
   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_ANSWER = 2'b10
   } bus_phase_t;

   // Address compare shared by the flag, mask, start and stop write decodes
   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   // Anything outside the six words of the map counts as reserved
   function automatic logic addr_mapped(input logic [7:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (addr)
         OFF_IRQ_FLAGS, OFF_START, OFF_STOP, OFF_RUN, OFF_IRQ_MASK, OFF_KEY: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   apb_req_t req;
   bus_phase_t phase_r, phase_nxt;
   logic rdy_r, rdy_nxt;
   logic [7:0] flags_r, flags_nxt;
   logic [7:0] mask_r, mask_nxt;
   logic [1:0] run_r, run_nxt;
   logic [1:0] spulse_r, spulse_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic slverr_r, slverr_nxt;
   logic irq_r, irq_nxt;
   logic key_event, key_done;
   logic acc_first, acc_last;
   logic wr, rd, known;

   key_once u_key_once (
      .pclk(pclk),
      .presetn(presetn),
      .key_down(key_down),
      .key_event(key_event),
      .key_done(key_done)
   );

   // ----------------------------------------
   // Bus handshake, one wait state
   // ----------------------------------------
   // Read data and the error flag are registered in the first access
   // cycle and stand with pready in the second. Writes land only on the
   // edge that completes the transfer, so none is applied twice.
   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign acc_first = psel && penable && (phase_r == PH_IDLE);
   assign acc_last = psel && penable && (phase_r == PH_ANSWER);
   assign wr = acc_last && req.write;
   assign rd = acc_first && !req.write;
   assign known = addr_mapped(req.addr);

   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         PH_IDLE: begin
            if (psel && penable) begin
               phase_nxt = PH_ANSWER;
            end
         end
         PH_ANSWER: begin
            phase_nxt = PH_IDLE;
         end
      endcase
      rdy_nxt = (phase_nxt == PH_ANSWER);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= PH_IDLE;
         rdy_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   // ----------------------------------------
   // Interrupt request flags
   // ----------------------------------------
   always_comb begin
      flags_nxt = flags_r;
      // Clear first, so an event in the same cycle wins
      if (wr && addr_is(req.addr, OFF_IRQ_FLAGS)) begin
         flags_nxt = flags_r & ~req.wdata[7:0];
      end
      if (chan0_event) begin
         flags_nxt[CHAN0_IRQ_BIT] = 1'b1;
      end
      if (key_event) begin
         flags_nxt[KEY_DOWN_POS] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // ----------------------------------------
   // Interrupt mask
   // ----------------------------------------
   always_comb begin
      mask_nxt = mask_r;
      if (wr && addr_is(req.addr, OFF_IRQ_MASK)) begin
         mask_nxt = req.wdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= MASK_RESET;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // ----------------------------------------
   // Run enables and start pulses
   // ----------------------------------------
   always_comb begin
      run_nxt = run_r;
      spulse_nxt = 2'h0;
      // Start and stop sit at different offsets, so one write never carries both
      if (wr && addr_is(req.addr, OFF_STOP) && req.wdata[CHAN1_STOP_POS]) begin
         run_nxt[1] = 1'b0;
      end
      if (wr && addr_is(req.addr, OFF_START)) begin
         run_nxt = run_nxt | (req.wdata[1:0] & START_VALID[1:0]);
         spulse_nxt = req.wdata[1:0] & START_VALID[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= RUN_RESET;
         spulse_r <= 2'h0;
      end else begin
         run_r <= run_nxt;
         spulse_r <= spulse_nxt;
      end
   end

   // ----------------------------------------
   // Read data and error response
   // ----------------------------------------
   // Both stand for the answer cycle only and drop back to zero after it
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      slverr_nxt = 1'b0;
      if (acc_first) begin
         // Reserved addresses answer with an error and have no effect
         slverr_nxt = !known;
      end
      if (rd) begin
         unique case (req.addr)
            OFF_IRQ_FLAGS: rdata_nxt[7:0] = flags_r;
            OFF_IRQ_MASK: rdata_nxt[7:0] = mask_r;
            OFF_RUN: rdata_nxt[1:0] = run_r;
            OFF_KEY: begin
               rdata_nxt[KEY_DOWN_POS] = key_down;
               rdata_nxt[KEY_DONE_POS] = key_done;
            end
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         slverr_r <= slverr_nxt;
      end
   end

   // ----------------------------------------
   // Interrupt output
   // ----------------------------------------
   // Taken from next-state values so the level changes on the same edge as the write it follows
   always_comb begin
      irq_nxt = |(flags_nxt & mask_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = rdata_r;
   assign pready = rdy_r;
   assign pslverr = slverr_r;
   assign chan_run_enable = run_r;
   assign start_pulse_0 = spulse_r[0];
   assign start_pulse_1 = spulse_r[1];
   assign irq = irq_r;
endmodule // timer_start_stop_triggers

// file: verification/tss_asserts.sv
`timescale 1ns/1ps
module tss_asserts
   import timer_trig_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [1:0] chan_run_enable,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic start_pulse_0
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic w = psel && penable && pwrite && pready;
   wire logic r = psel && penable && !pwrite && pready;
   a_start_sets: assert property (w && paddr == OFF_START |=>
      (chan_run_enable & $past(pwdata[1:0])) == $past(pwdata[1:0])) else $error("start");
   a_stop_clears: assert property (w && paddr == OFF_STOP && pwdata[1] |=>
      !chan_run_enable[1]) else $error("stop");
   a_stop_zero_keeps: assert property (w && paddr == OFF_STOP && !pwdata[1] |=>
      chan_run_enable == $past(chan_run_enable)) else $error("stop with zero changed run enable");
   a_start_pulse: assert property (w && paddr == OFF_START && pwdata[0] |=>
      start_pulse_0) else $error("no start pulse");
   a_pulse_single: assert property (start_pulse_0 |=> !start_pulse_0) else $error("pulse held");
   a_trig_read_zero: assert property (r && (paddr == OFF_START || paddr == OFF_STOP) |->
      prdata == 32'h0000_0000) else $error("trigger read not zero");
endmodule // tss_asserts

// file: verification/tb_timer_start_stop_triggers.sv
`timescale 1ns/1ps
module tb_timer_start_stop_triggers;
   import timer_trig_pkg::*;
   logic pclk = 1'h0;
   logic presetn, psel, penable, pwrite, chan0_event, key_down, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [1:0] chan_run_enable;
   logic [31:0] pwdata, prdata, lf = 32'h2D36FC7F;
   int errors, checked, run;
   timer_start_stop_triggers u_timer_start_stop_triggers(.*, .start_pulse_0(), .start_pulse_1());
   task chk(input logic [31:0] s, e);
      checked++;
      errors += (s !== e);
      if (s !== e) $display("Error %0t %h %h", $time, s, e);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      {psel, penable} <= 2'h0;
   endtask
   function logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task tally_and_finish;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial forever #2 pclk = ~pclk;
   initial begin
      #20000;
      errors++;
      tally_and_finish;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, chan0_event, key_down, presetn} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      for (int i = 0; i < 24; i++) begin
         lf = nx(lf);
         apb(1, OFF_START, lf[7:0]);
         run |= lf[1:0];
         apb(1, OFF_STOP, lf[15:8]);
         if (lf[9]) run &= 1;
         @(posedge pclk);
         chk(chan_run_enable, run);
         apb(0, lf[2] ? OFF_START : OFF_STOP, 0);
         chk(prdata, 0);
      end
      chan0_event <= 1'h1;
      apb(0, OFF_IRQ_FLAGS, 0);
      chan0_event <= 1'h0;
      chk(prdata, 32'h80);
      apb(1, OFF_IRQ_MASK, 32'h80);
      @(posedge pclk);
      chk(irq, 1'h1);
      apb(1, OFF_IRQ_FLAGS, 32'h80);
      @(posedge pclk);
      chk(irq, 1'h0);
      key_down <= 1'h1;
      repeat (4) @(posedge pclk);
      apb(0, OFF_KEY, 0);
      chk(prdata, 32'h3);
      apb(1, OFF_IRQ_FLAGS, 32'h1);
      repeat (4) @(posedge pclk);
      apb(0, OFF_IRQ_FLAGS, 0);
      chk(prdata, 0);
      key_down <= 1'h0;
      repeat (4) @(posedge pclk);
      apb(0, OFF_KEY, 0);
      chk(prdata, 0);
      apb(0, 8'hFC, 0);
      chk(pslverr, 1'h1);
      tally_and_finish;
   end
endmodule // tb_timer_start_stop_triggers
bind timer_start_stop_triggers tss_asserts u_tss_asserts(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .chan_run_enable(chan_run_enable),
   .pready(pready),
   .prdata(prdata),
   .start_pulse_0(start_pulse_0)
);
